/* amc_pkg.sv */
/*
  Constants, types and helper functions for the converter mode and configuration control.
  Assumes a 40 MHz system clock and a host that shifts control words MSB first on the serial clock.
*/
// Overview of operation
// [R1] Any gain pin high selects pin-driven mode.
// [R2] Gain pins all low select register mode.
// [R3] Codes 1 to 14 map to gains 1..128.
// [R4] Gain code all ones keeps previous gain.
// [R5] Power-down code decodes to unit enables.
// [R6] Pin-driven code 000 powers everything down.
// [R7] Code 101 powers every unit on.
// [R8] Code 111 resets only in pin-driven mode.
// [R9] That reset clears registers, leaves units off.
// [R10] Register mode powers up off, gain 1.
// [R11] Not ready 15 us external, 240 us internal.
// [R12] Twelve-bit control word, readable and writable.
// [R13] In register mode lowest power-down pin is data.
// [R14] Sample data on falling clock, select low.
// [R15] Four address bits then twelve data bits.
// [R16] Seventeenth clock commits the shifted word.
// [R17] Host sends address 0001 for control word.
// [R18] Only the addressed twelve bits are loaded.
// [R19] New word applies at next conversion.
// [R20] Fields: readback select, calibrate, power-down, gain.
// [R21] Host sends zero readback select normally.
// [R22] MSB first; control word resets to zero.
// [R23] Host holds upper power-down pins low.
// [R24] Pin mode: calibrate and reference pins act.
// [R25] Mode follows gain pins continuously.

package amc_pkg;

  // ----------------------------------------------------------------
  // Serial frame
  // ----------------------------------------------------------------
  localparam int CW_W = 12;
  localparam int ADDR_W = 4;
  localparam int FRAME_BITS = ADDR_W + CW_W;
  localparam logic [4:0] CNT_LAST_BIT = 5'h10;
  localparam logic [4:0] CNT_DONE = 5'h11;
  localparam logic [3:0] WR_CTRL = 4'h1;
  localparam logic [11:0] CW_RESET = 12'h000;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] GAIN_REG_MODE = 4'h0;
  localparam logic [3:0] GAIN_DEFAULT = 4'h1;
  localparam logic [3:0] GAIN_RSVD = 4'hF;
  localparam logic [2:0] PD_ALL_OFF = 3'h0;
  localparam logic [2:0] PD_ADC = 3'h1;
  localparam logic [2:0] PD_FAST = 3'h2;
  localparam logic [2:0] PD_LOWP = 3'h3;
  localparam logic [2:0] PD_CMP = 3'h4;
  localparam logic [2:0] PD_ALL_ON = 3'h5;
  localparam logic [2:0] PD_RESET = 3'h7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int T_RDY_EXT_NS = 15000;
  localparam int T_RDY_INT_NS = 240000;
  localparam int RDY_EXT_CYC = (T_RDY_EXT_NS * CLK_MHZ + 999) / 1000;
  localparam int RDY_INT_CYC = (T_RDY_INT_NS * CLK_MHZ + 999) / 1000;
  localparam int RDY_CNT_W = 14;

  // Synchroniser vector: cs_n, toggle, cal, ref, pd[2:0], gain[3:0].
  localparam int SYNC_W = 11;
  localparam logic [10:0] SYNC_RST = 11'h400;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] rd_sel;
    logic cal;
    logic [2:0] pd;
    logic [3:0] gain;
  } amc_cw_t;

  typedef struct packed {
    logic lowp_en;
    logic fast_en;
    logic adc_en;
  } amc_units_t;

  typedef struct packed {
    logic [3:0] gain;
    logic [7:0] factor;
    amc_units_t units;
    logic cal;
  } amc_apply_t;

  typedef enum logic [0:0] {
    AMC_WARM = 1'b0,
    AMC_RUN = 1'b1
  } amc_rdy_t;

  localparam amc_apply_t APPLY_RESET = '{gain: GAIN_DEFAULT, factor: 8'h01, units: 3'h0, cal: 1'b0};

  function automatic logic [7:0] amc_gain_factor(input logic [3:0] code);
    case (code)
      4'h1: amc_gain_factor = 8'h01;
      4'h2: amc_gain_factor = 8'h02;
      4'h3: amc_gain_factor = 8'h03;
      4'h4: amc_gain_factor = 8'h04;
      4'h5: amc_gain_factor = 8'h06;
      4'h6: amc_gain_factor = 8'h08;
      4'h7: amc_gain_factor = 8'h0C;
      4'h8: amc_gain_factor = 8'h10;
      4'h9: amc_gain_factor = 8'h18;
      4'hA: amc_gain_factor = 8'h20;
      4'hB: amc_gain_factor = 8'h30;
      4'hC: amc_gain_factor = 8'h40;
      4'hD: amc_gain_factor = 8'h60;
      4'hE: amc_gain_factor = 8'h80;
      default: amc_gain_factor = 8'h00;
    endcase
  endfunction

  function automatic amc_units_t amc_pd_decode(input logic [2:0] pd);
    case (pd)
      PD_ADC: amc_pd_decode = '{lowp_en: 1'b0, fast_en: 1'b0, adc_en: 1'b1};
      PD_FAST: amc_pd_decode = '{lowp_en: 1'b0, fast_en: 1'b1, adc_en: 1'b0};
      PD_LOWP: amc_pd_decode = '{lowp_en: 1'b1, fast_en: 1'b0, adc_en: 1'b0};
      PD_CMP: amc_pd_decode = '{lowp_en: 1'b1, fast_en: 1'b1, adc_en: 1'b0};
      PD_ALL_ON: amc_pd_decode = '{lowp_en: 1'b1, fast_en: 1'b1, adc_en: 1'b1};
      default: amc_pd_decode = '{lowp_en: 1'b0, fast_en: 1'b0, adc_en: 1'b0};
    endcase
  endfunction

endpackage

/* amc_mode_ctrl.sv */
/*
  Mode and configuration control: pin-driven decode, serial control word loading, applied settings
  and the power-up ready timer.
  Assumes the serial clock idles between frames and chip select and pins are asynchronous to SYS_CLK_I.
*/
`timescale 1ns/1ps
`default_nettype none

module amc_mode_ctrl
  import amc_pkg::*;
#(
  parameter int READY_EXT_CYC = RDY_EXT_CYC,
  parameter int READY_INT_CYC = RDY_INT_CYC
) (
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire logic SERIAL_CLK_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic [3:0] GAIN_SELECT_PINS_I,
  input wire logic [2:0] POWER_DOWN_SELECT_I,
  input wire logic REFERENCE_SOURCE_SELECT_I,
  input wire logic CAL_START_I,
  output logic REG_MODE_O,
  output logic [3:0] GAIN_CODE_O,
  output logic [7:0] GAIN_FACTOR_O,
  output logic ADC_EN_O,
  output logic FAST_CMP_EN_O,
  output logic LOWP_CMP_EN_O,
  output logic CAL_O,
  output logic REF_INT_O,
  output logic READY_O,
  output logic [11:0] CTRL_WORD_O,
  output logic [3:0] READBACK_REGISTER_SELECT_O
);

  generate
    if (READY_EXT_CYC < 1 || READY_INT_CYC < 1 || READY_EXT_CYC >= 2 ** RDY_CNT_W ||
        READY_INT_CYC >= 2 ** RDY_CNT_W) begin : g_bad_param
      $error("Ready cycle counts must lie between 1 and the counter range.");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Serial link domain
  // ----------------------------------------------------------------
  // The frame counter is held cleared while chip select is high.
  logic lnk_rst_n;
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [11:0] hold_word;
  logic [11:0] next_hold_word;
  logic lnk_tog;
  logic next_lnk_tog;
  logic lnk_commit;

  assign lnk_rst_n = NRST_I & ~CHIP_SELECT_N_I;

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    if (bit_cnt < CNT_DONE) begin // R18
      next_bit_cnt = bit_cnt + 5'h01; // R15
    end
    if (bit_cnt < CNT_LAST_BIT) begin
      next_shift = {shift[14:0], POWER_DOWN_SELECT_I[0]}; // R13 R22
    end
  end

  always_ff @(negedge SERIAL_CLK_I or negedge lnk_rst_n) begin // R14
    if (!lnk_rst_n) begin
      bit_cnt <= 5'h00;
      shift <= 16'h0000;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
    end
  end

  assign lnk_commit = (bit_cnt == CNT_LAST_BIT) && (shift[15:12] == WR_CTRL); // R16 R17

  always_comb begin
    next_hold_word = hold_word;
    next_lnk_tog = lnk_tog;
    if (lnk_commit) begin
      next_hold_word = shift[11:0]; // R18
      next_lnk_tog = ~lnk_tog;
    end
  end

  // Held word stays stable until the next frame, so the system side may sample it after the toggle.
  always_ff @(negedge SERIAL_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      hold_word <= CW_RESET;
      lnk_tog <= 1'b0;
    end else begin
      hold_word <= next_hold_word;
      lnk_tog <= next_lnk_tog;
    end
  end

  // ----------------------------------------------------------------
  // Synchronisers into the system clock
  // ----------------------------------------------------------------
  logic [10:0] sync_a;
  logic [10:0] sync_b;
  logic [10:0] next_sync_a;
  logic cs_prev;
  logic tog_prev;

  always_comb begin
    next_sync_a = {CHIP_SELECT_N_I, lnk_tog, CAL_START_I, REFERENCE_SOURCE_SELECT_I,
                   POWER_DOWN_SELECT_I, GAIN_SELECT_PINS_I};
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
      cs_prev <= 1'b1;
      tog_prev <= 1'b0;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= sync_a;
      cs_prev <= sync_b[10];
      tog_prev <= sync_b[9];
    end
  end

  logic cs_s;
  logic cal_s;
  logic ref_s;
  logic [2:0] pd_s;
  logic [3:0] gain_s;
  logic is_reg;
  logic pin_rst;
  logic commit;
  logic conv_start;

  assign cs_s = sync_b[10];
  assign cal_s = sync_b[8];
  assign ref_s = sync_b[7];
  assign pd_s = sync_b[6:4];
  assign gain_s = sync_b[3:0];
  assign is_reg = (gain_s == GAIN_REG_MODE); // R1 R2 R25
  assign pin_rst = !is_reg && (pd_s == PD_RESET); // R8
  assign commit = (sync_b[9] != tog_prev);
  assign conv_start = cs_prev && !cs_s;

  // ----------------------------------------------------------------
  // Control word and applied configuration
  // ----------------------------------------------------------------
  amc_cw_t cw;
  amc_cw_t next_cw;
  amc_apply_t app;
  amc_apply_t next_app;
  logic next_reg_mode;
  logic next_ref_int;

  always_comb begin
    next_cw = cw;
    next_app = app;
    next_reg_mode = is_reg;
    next_ref_int = ref_s; // R24
    if (pin_rst) begin
      next_cw = CW_RESET; // R9
      next_app = APPLY_RESET; // R9
    end else begin
      if (commit && is_reg) begin
        next_cw = hold_word; // R12 R16
      end
      if (!is_reg) begin
        if (gain_s != GAIN_RSVD) begin // R4
          next_app.gain = gain_s; // R3
        end
        next_app.units = amc_pd_decode(pd_s); // R5 R6 R7
        next_app.cal = cal_s; // R24
      end else if (conv_start) begin // R19
        if (cw.gain == GAIN_REG_MODE) begin
          next_app.gain = GAIN_DEFAULT; // R10
        end else if (cw.gain != GAIN_RSVD) begin // R4
          next_app.gain = cw.gain; // R2
        end
        next_app.units = amc_pd_decode(cw.pd); // R5
        next_app.cal = cw.cal; // R20
      end
    end
    next_app.factor = amc_gain_factor(next_app.gain); // R3
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cw <= CW_RESET; // R22
      app <= APPLY_RESET; // R10
      REG_MODE_O <= 1'b1;
      REF_INT_O <= 1'b0;
    end else begin
      cw <= next_cw;
      app <= next_app;
      REG_MODE_O <= next_reg_mode;
      REF_INT_O <= next_ref_int;
    end
  end

  assign GAIN_CODE_O = app.gain;
  assign GAIN_FACTOR_O = app.factor;
  assign ADC_EN_O = app.units.adc_en;
  assign FAST_CMP_EN_O = app.units.fast_en;
  assign LOWP_CMP_EN_O = app.units.lowp_en;
  assign CAL_O = app.cal;
  assign CTRL_WORD_O = cw;
  assign READBACK_REGISTER_SELECT_O = cw.rd_sel;

  // ----------------------------------------------------------------
  // Power-up ready timer
  // ----------------------------------------------------------------
  amc_rdy_t rdy_state;
  amc_rdy_t next_rdy_state;
  logic [13:0] warm_cnt;
  logic [13:0] next_warm_cnt;
  logic [13:0] warm_lim;
  logic next_ready;

  // Limit follows the reference pin so a late strap still gets the longer wait.
  assign warm_lim = ref_s ? 14'(READY_INT_CYC) : 14'(READY_EXT_CYC); // R11

  always_comb begin
    next_rdy_state = rdy_state;
    next_warm_cnt = warm_cnt;
    case (rdy_state)
      AMC_WARM: begin
        if (warm_cnt >= warm_lim - 14'h0001) begin
          next_rdy_state = AMC_RUN; // R11
        end else begin
          next_warm_cnt = warm_cnt + 14'h0001;
        end
      end
      AMC_RUN: begin
        next_rdy_state = AMC_RUN;
      end
      default: begin
        next_rdy_state = AMC_WARM;
      end
    endcase
    if (pin_rst) begin
      next_rdy_state = AMC_WARM; // R9
      next_warm_cnt = 14'h0000;
    end
    next_ready = (next_rdy_state == AMC_RUN);
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdy_state <= AMC_WARM;
      warm_cnt <= 14'h0000;
      READY_O <= 1'b0;
    end else begin
      rdy_state <= next_rdy_state;
      warm_cnt <= next_warm_cnt;
      READY_O <= next_ready;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_pin_gain_map: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R3
    (!is_reg && gain_s != GAIN_RSVD && pd_s != PD_RESET) |=> (GAIN_CODE_O == $past(gain_s)))
    else $error("Pin gain code not applied.");

  a_gain_factor: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R3
    GAIN_FACTOR_O == amc_gain_factor(GAIN_CODE_O))
    else $error("Gain factor does not match gain code.");

  a_rsvd_gain_keep: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R4
    (!is_reg && gain_s == GAIN_RSVD && pd_s != PD_RESET) |=> $stable(GAIN_CODE_O))
    else $error("Reserved gain code changed the gain.");

  a_pin_all_off: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R6
    (!is_reg && pd_s == PD_ALL_OFF) |=> (!ADC_EN_O && !FAST_CMP_EN_O && !LOWP_CMP_EN_O))
    else $error("Units powered while power-down code is zero.");

  a_pin_all_on: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R7
    (!is_reg && pd_s == PD_ALL_ON) |=> (ADC_EN_O && FAST_CMP_EN_O && LOWP_CMP_EN_O))
    else $error("Full power code did not enable all units.");

  a_pin_reset: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
    pin_rst |=> (CTRL_WORD_O == CW_RESET && !ADC_EN_O && !FAST_CMP_EN_O && !LOWP_CMP_EN_O && !READY_O))
    else $error("Pin reset did not clear state.");

  a_reg_no_reset: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R8
    (is_reg && commit) |=> (CTRL_WORD_O == $past(hold_word)))
    else $error("Committed word not loaded in register mode.");

  a_next_conv: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R19
    (is_reg && !conv_start) |=> ($stable(GAIN_CODE_O) && $stable(ADC_EN_O) && $stable(CAL_O)))
    else $error("Register settings applied outside a conversion start.");

  a_ready_time: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R11
    $rose(READY_O) |-> ($past(warm_cnt) == $past(warm_lim) - 14'h0001))
    else $error("Ready asserted at the wrong time.");

  // Checked on the rising serial edge, which still falls inside the frame after the seventeenth fall.
  a_frame_len: assert property (@(posedge SERIAL_CLK_I) disable iff (!NRST_I) // R15 R16
    (lnk_tog != $past(lnk_tog)) |-> (bit_cnt == CNT_DONE && $past(bit_cnt) == CNT_LAST_BIT))
    else $error("Commit did not occur on the seventeenth edge.");

  a_mode_follow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R1 R2 R25
    1'b1 |=> (REG_MODE_O == $past(is_reg)))
    else $error("Mode output does not follow the gain pins.");

  a_pin_cal: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R24
    (!is_reg && !pin_rst) |=> (CAL_O == $past(cal_s)))
    else $error("Calibration pin not applied in pin-driven mode.");

  a_ref_follow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R24
    1'b1 |=> (REF_INT_O == $past(ref_s)))
    else $error("Reference select does not follow its pin.");

  a_reg_conv_apply: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R2 R19 R20
    (is_reg && conv_start && cw.gain != GAIN_RSVD && cw.gain != GAIN_REG_MODE) |=>
    (GAIN_CODE_O == $past(cw.gain) && CAL_O == $past(cw.cal)))
    else $error("Control word not applied at conversion start.");

  a_reg_rsvd_keep: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I) // R4
    (is_reg && conv_start && cw.gain == GAIN_RSVD) |=> $stable(GAIN_CODE_O))
    else $error("Reserved word gain changed the gain.");

  c_reg_commit: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) is_reg && commit);
  c_conv_apply: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) is_reg && conv_start && cw.pd != 3'h0);
  c_pin_reset: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) pin_rst);
  c_ready: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) $rose(READY_O));

endmodule // amc_mode_ctrl

`default_nettype wire

/* amc_host_model.sv */
/*
  Host serial port model that writes control words into the mode and configuration control.
  Assumes the bench calls send() and routes the data line to the lowest power-down pin in register mode.
*/
`timescale 1ns/1ps
`default_nettype none

module amc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdata_o
);
  // ----------------------------------------------------------------
  // Serial frame driver
  // ----------------------------------------------------------------
  localparam realtime HALF = 62.5;

  // The serial clock idles high and stands still between frames.
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    sdata_o = 1'b0;
  end

  task automatic send(input logic [3:0] addr, input logic [11:0] word, input int edges);
    logic [15:0] frame;
    frame = {addr, word};
    #7;
    cs_n_o = 1'b0;
    sdata_o = frame[15];
    #(HALF);
    for (int i = 1; i <= edges; i++) begin
      sclk_o = 1'b0;
      #(HALF);
      sclk_o = 1'b1;
      if (i < 16) begin
        sdata_o = frame[15 - i];
      end else begin
        sdata_o = ~sdata_o;
      end
      #(HALF);
    end
    cs_n_o = 1'b1;
    sdata_o = ~sdata_o;
  endtask
endmodule // amc_host_model

`default_nettype wire

/* adc_mode_config_control_tb_top.sv */
/*
  Self-checking bench for the mode and configuration control.
  Assumes small ready limits of 10 and 20 cycles and the host model for serial writes.
*/
`timescale 1ns/1ps
`default_nettype none

module adc_mode_config_control_tb_top;
  import amc_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] gain = 4'h0;
  logic [2:0] pd_pins = 3'h0;
  logic ref_sel = 1'b0;
  logic cal = 1'b0;
  wire logic sclk, cs_n, sdata;
  wire logic [2:0] pd_bus = (gain == 4'h0) ? {pd_pins[2:1], sdata} : pd_pins;
  logic reg_mode, adc_en, fast_en, lowp_en, cal_o, ref_int, ready;
  logic [3:0] gain_code, rd_sel;
  logic [7:0] factor;
  logic [11:0] ctrl_word;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] exp_gain [1:14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10, 8'h18,
                                  8'h20, 8'h30, 8'h40, 8'h60, 8'h80};
  logic [2:0] exp_units [0:5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h3, 3'h7};

  always #12.5 clk = ~clk;

  amc_host_model i_amc_host_model (.sclk_o(sclk), .cs_n_o(cs_n), .sdata_o(sdata));

  amc_mode_ctrl #(.READY_EXT_CYC(10), .READY_INT_CYC(20)) i_amc_mode_ctrl (
    .SYS_CLK_I(clk), .NRST_I(nrst), .SERIAL_CLK_I(sclk), .CHIP_SELECT_N_I(cs_n),
    .GAIN_SELECT_PINS_I(gain), .POWER_DOWN_SELECT_I(pd_bus), .REFERENCE_SOURCE_SELECT_I(ref_sel),
    .CAL_START_I(cal), .REG_MODE_O(reg_mode), .GAIN_CODE_O(gain_code), .GAIN_FACTOR_O(factor),
    .ADC_EN_O(adc_en), .FAST_CMP_EN_O(fast_en), .LOWP_CMP_EN_O(lowp_en), .CAL_O(cal_o),
    .REF_INT_O(ref_int), .READY_O(ready), .CTRL_WORD_O(ctrl_word),
    .READBACK_REGISTER_SELECT_O(rd_sel));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pins(input logic [3:0] g, input logic [2:0] p);
    @(posedge clk);
    gain <= g;
    pd_pins <= p;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic frame(input logic [3:0] addr, input logic [11:0] word, input int edges);
    i_amc_host_model.send(addr, word, edges);
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic final_report();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check("reg_mode", reg_mode, 1);
    check("gain_code", gain_code, 1);
    check("units", {adc_en, fast_en, lowp_en}, 0);
    check("ctrl_word", ctrl_word, 0);
    check("ready", ready, 0);
    repeat (20) @(posedge clk);
    #1;
    check("ready", ready, 1);
    // Register mode: commit waits for the next conversion start to apply.
    frame(4'h1, 12'h0D3, 17);
    check("ctrl_word", ctrl_word, 12'h0D3);
    check("gain_code", gain_code, 1);
    frame(4'h2, 12'hFFF, 17);
    check("ctrl_word", ctrl_word, 12'h0D3);
    check("gain_code", gain_code, 3);
    check("factor", factor, 3);
    check("units", {adc_en, fast_en, lowp_en}, 3'h7);
    check("cal", cal_o, 1);
    frame(4'h1, 12'h0A5, 16);
    check("ctrl_word", ctrl_word, 12'h0D3);
    frame(4'h1, 12'h50F, 17);
    check("rd_sel", rd_sel, 4'h5);
    // The next conversion start applies the word with the reserved gain code.
    frame(4'h2, 12'h000, 17);
    check("ctrl_word", ctrl_word, 12'h50F);
    check("gain_code", gain_code, 3);
    check("units", {adc_en, fast_en, lowp_en}, 0);
    check("cal", cal_o, 0);
    // Pin-driven mode: gain table and reserved code.
    for (int c = 1; c <= 14; c++) begin
      pins(4'(c), 3'h5);
      check("reg_mode", reg_mode, 0);
      check("gain_code", gain_code, 12'(c));
      check("factor", factor, exp_gain[c]);
    end
    pins(4'hF, 3'h5);
    check("factor", factor, 8'h80);
    for (int p = 0; p <= 5; p++) begin
      pins(4'h2, 3'(p));
      check("units", {adc_en, fast_en, lowp_en}, exp_units[p]);
    end
    @(posedge clk);
    cal <= 1'b1;
    ref_sel <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check("cal", cal_o, 1);
    check("ref_int", ref_int, 1);
    @(posedge clk);
    cal <= 1'b0;
    // Pin reset clears the word and restarts the ready timer.
    pins(4'h2, 3'h7);
    check("units", {adc_en, fast_en, lowp_en}, 0);
    check("ctrl_word", ctrl_word, 0);
    check("ready", ready, 0);
    pins(4'h2, 3'h5);
    check("ready", ready, 0);
    check("cal", cal_o, 0);
    repeat (30) @(posedge clk);
    #1;
    check("ready", ready, 1);
    pins(4'h0, 3'h0);
    check("reg_mode", reg_mode, 1);
    final_report();
  end
endmodule // adc_mode_config_control_tb_top

`default_nettype wire
